// File: design/adc_alarm_cfg.svh
/*
 * Offsets, field positions, reset values and widths of the alarm and
 * chain port block. Assumes byte addressing on a 32-bit APB.
 */
`ifndef ADC_ALARM_CFG_SVH
`define ADC_ALARM_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define RESULT_W      16
`define HYST_W        8
`define SHIFT_W       32
`define CNT_W         6
`define ADDR_W        12
`define SRC_N         4

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_HIGH_TH   12'h004
`define OFS_LOW_TH    12'h008
`define OFS_HYST      12'h00c
`define OFS_FLAGS     12'h010
`define OFS_RESULT    12'h014
`define OFS_COMMAND   12'h018

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RST_CTRL      5'h00
`define RST_HIGH_TH   16'hffff
`define RST_LOW_TH    16'h0000
`define RST_HYST      8'h00
`define FUNC_ALARM    2'h1
`define CMD_NOP       32'h0000_0000
`define FULL_FRAME    6'h20

// ----------------------------------------------------------------
// Alarm source index
// ----------------------------------------------------------------
`define SRC_IN_HIGH   0
`define SRC_IN_LOW    1
`define SRC_SUP_LOW   2
`define SRC_SUP_HIGH  3

`endif

// File: design/adc_alarm_pkg.sv
/*
 * Types shared by the alarm and chain port block.
 * Assumes the constants header is included alongside.
 */
package adc_alarm_pkg;

    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic       append_flags;
        logic       supply_alarm_disable;
        logic       input_alarm_disable;
        logic [1:0] second_output_function_select;
    } output_port_control_s;

    // ------------------------------------------------------------
    // Alarm flag register layout
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] tripped;
        logic [3:0] active;
    } alarm_flags_s;

    // ------------------------------------------------------------
    // Serial link pins toward the device
    // ------------------------------------------------------------
    typedef struct packed {
        logic sdi;
        logic sclk;
        logic conversion_start_select;
    } serial_in_s;

    typedef enum logic {
        FRAME_IDLE = 1'b0,
        FRAME_XFER = 1'b1
    } frame_e;

endpackage

// File: design/adc_alarm_and_chain_port.sv
/*
 * Result path of a 16-bit converter: alarm monitor with thresholds
 * and hysteresis, supply alarm, alarm pin, APB registers and a
 * 32-bit chainable shift-register serial port.
 * Assumes the converter core delivers result and done on ref_clk;
 * serial pins and supply comparators are asynchronous.
 */
// Design decisions made here: the APB slave port and the register addresses.
//
// How it works
// - Results pass as unsigned straight-binary codes for every input range.
// - Result code is 16 bits; one step is span over two to sixteen.
// - Alarm pin acts as active-high alarm only when function select is 01.
// - Result compared against high and low thresholds raises input alarm.
// - Supply comparators beyond low or high trip point raise supply alarm.
// - Both alarms enabled by default, each with its own disable bit.
// - Each source sets its active and tripped flags together.
// - Active flags are recomputed at every end of conversion.
// - Tripped flags hold until the flag register is read.
// - Flags update at conversion end and are loaded into frames when append_flags is set.
// - Flags optionally appended to the serial result word.
// - High alarm sets above T, clears at or below T minus H minus 1.
// - Low alarm sets below T, clears at or above T plus H plus 1.
// - Alarm pin high while any enabled alarm is present.
// - Separate high and low thresholds share one hysteresis value.
// - Frame shifts in and out together as one 32-bit register.
// - Select rising edge starts sampling; falling edge opens the frame.
// - Launch edge drives MSB out; capture edge shifts input into LSB.
// - Select rising edge hands the shift register to command decode.
// - Select fall loads output word and resets command to no-op.
// - Under 32 clocks is a no-op; otherwise last 32 bits form command.
`timescale 1ns/10ps
`include "adc_alarm_cfg.svh"

module adc_alarm_and_chain_port (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`ADDR_W-1:0]        paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Converter core
    input  wire logic                      conv_done,
    input  wire logic [`RESULT_W-1:0]      conv_result,
    output logic                           conv_start,
    // Supply comparators
    input  wire logic                      supply_low_cmp,
    input  wire logic                      supply_high_cmp,
    // Serial link
    input  wire adc_alarm_pkg::serial_in_s link_in,
    output logic                           primary_serial_output,
    output logic                           primary_serial_output_oe,
    // Multifunction pin
    output logic                           multifunction_alarm_pin,
    output logic                           multifunction_alarm_pin_oe,
    // Command processor
    output logic      [`SHIFT_W-1:0]       command_word,
    output logic                           command_valid
);
    import adc_alarm_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_raw;
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;

    assign pin_raw = {supply_high_cmp, supply_low_cmp, link_in};

    genvar g;
    generate
        for (g = 0; g < 5; g = g + 1)
        begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    sync1_q[g] <= (g == 0); // Select idles high
                    sync2_q[g] <= (g == 0);
                end
                else
                begin
                    sync1_q[g] <= pin_raw[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    wire cs_s      = sync2_q[0];
    wire sclk_s    = sync2_q[1];
    wire sdi_s     = sync2_q[2];
    wire sup_low_s = sync2_q[3];
    wire sup_hi_s  = sync2_q[4];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    output_port_control_s   ctrl_q;
    logic [`RESULT_W-1:0]   high_th_q;
    logic [`RESULT_W-1:0]   low_th_q;
    logic [`HYST_W-1:0]     hyst_q;
    logic [`RESULT_W-1:0]   result_q;
    logic                   hi_state_q;
    logic                   lo_state_q;
    alarm_flags_s           flags_q;
    logic                   cs_prev_q;
    logic                   sclk_prev_q;
    frame_e                 frame_q;
    frame_e                 frame_d;
    logic [`SHIFT_W-1:0]    sr_q;
    logic [`CNT_W-1:0]      count_q;
    logic [`SHIFT_W-1:0]    cmd_q;
    logic                   cmd_valid_q;
    logic                   conv_start_q;
    logic                   sdo_q;
    logic                   sdo_oe_q;
    logic                   alarm_q;
    logic                   alarm_oe_q;
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire apb_acc   = psel & penable;
    wire apb_first = apb_acc & ~pready_q;
    wire apb_done  = apb_acc & pready_q;
    wire apb_wr    = apb_done & pwrite;
    wire sel_ctrl  = (paddr == `OFS_CTRL);
    wire sel_hi    = (paddr == `OFS_HIGH_TH);
    wire sel_lo    = (paddr == `OFS_LOW_TH);
    wire sel_hyst  = (paddr == `OFS_HYST);
    wire sel_flags = (paddr == `OFS_FLAGS);
    wire sel_res   = (paddr == `OFS_RESULT);
    wire sel_cmd   = (paddr == `OFS_COMMAND);
    wire addr_hit  = sel_ctrl | sel_hi | sel_lo | sel_hyst | sel_flags
                   | sel_res | sel_cmd;
    wire flag_read = apb_done & ~pwrite & sel_flags;

    wire [31:0] rd_mux =
        sel_ctrl  ? {27'h0000000, ctrl_q}   :
        sel_hi    ? {16'h0000, high_th_q}   :
        sel_lo    ? {16'h0000, low_th_q}    :
        sel_hyst  ? {24'h000000, hyst_q}    :
        sel_flags ? {24'h000000, flags_q}   :
        sel_res   ? {16'h0000, result_q}    :
        sel_cmd   ? cmd_q                   :
                    32'h0000_0000;

    // One wait state so that read data comes straight from a flop
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
        else
        begin
            pready_q  <= apb_first;
            pslverr_q <= apb_first & ~addr_hit;
            prdata_q  <= apb_first ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q    <= `RST_CTRL;
            high_th_q <= `RST_HIGH_TH;
            low_th_q  <= `RST_LOW_TH;
            hyst_q    <= `RST_HYST;
        end
        else
        begin
            if (apb_wr && sel_ctrl)
                ctrl_q <= pwdata[4:0];
            if (apb_wr && sel_hi)
                high_th_q <= pwdata[15:0];
            if (apb_wr && sel_lo)
                low_th_q <= pwdata[15:0];
            if (apb_wr && sel_hyst)
                hyst_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Input alarm with hysteresis
    // ------------------------------------------------------------
    // Release limits are done in 17 bits so T-H-1 cannot wrap
    wire [16:0] res_x   = {1'b0, conv_result};
    wire [16:0] hyst_x  = {9'h000, hyst_q};
    wire        hi_trip = conv_result > high_th_q;
    wire        lo_trip = conv_result < low_th_q;
    wire        hi_rel  = (res_x + hyst_x + 17'h00001)
                          <= {1'b0, high_th_q};
    wire        lo_rel  = res_x >= ({1'b0, low_th_q} + hyst_x
                          + 17'h00001);
    wire        hi_next = hi_state_q ? ~hi_rel : hi_trip;
    wire        lo_next = lo_state_q ? ~lo_rel : lo_trip;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hi_state_q <= 1'b0;
            lo_state_q <= 1'b0;
            result_q   <= 16'h0000;
        end
        else if (conv_done)
        begin
            hi_state_q <= hi_next;
            lo_state_q <= lo_next;
            result_q   <= conv_result;
        end
    end

    // ------------------------------------------------------------
    // Alarm flags
    // ------------------------------------------------------------
    logic [`SRC_N-1:0] src_cond;

    assign src_cond[`SRC_IN_HIGH]  = hi_next & ~ctrl_q.input_alarm_disable;
    assign src_cond[`SRC_IN_LOW]   = lo_next & ~ctrl_q.input_alarm_disable;
    assign src_cond[`SRC_SUP_LOW]  = sup_low_s & ~ctrl_q.supply_alarm_disable;
    assign src_cond[`SRC_SUP_HIGH] = sup_hi_s & ~ctrl_q.supply_alarm_disable;

    generate
        for (g = 0; g < `SRC_N; g = g + 1)
        begin : g_flag
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    flags_q.active[g]  <= 1'b0;
                    flags_q.tripped[g] <= 1'b0;
                end
                else
                begin
                    if (conv_done)
                        flags_q.active[g] <= src_cond[g];
                    // A new trip wins over a clearing read in the same cycle
                    if (conv_done && src_cond[g])
                        flags_q.tripped[g] <= 1'b1;
                    else if (flag_read)
                        flags_q.tripped[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Multifunction pin
    // ------------------------------------------------------------
    wire func_alarm = ctrl_q.second_output_function_select == `FUNC_ALARM;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            alarm_q    <= 1'b0;
            alarm_oe_q <= 1'b0;
        end
        else
        begin
            alarm_oe_q <= func_alarm;
            alarm_q    <= func_alarm & (|flags_q.active);
        end
    end

    // ------------------------------------------------------------
    // Serial frame control
    // ------------------------------------------------------------
    wire cs_fall   = cs_prev_q & ~cs_s;
    wire cs_rise   = ~cs_prev_q & cs_s;
    wire sclk_rise = ~sclk_prev_q & sclk_s;
    wire sclk_fall = sclk_prev_q & ~sclk_s;
    wire in_frame  = frame_q == FRAME_XFER;
    wire capture   = in_frame & ~cs_rise & sclk_rise;
    wire launch    = in_frame & ~cs_rise & sclk_fall;
    wire full_cnt  = count_q >= `FULL_FRAME;

    // Flags are taken at select fall, so a frame shows the last update
    wire [15:0] tail     = ctrl_q.append_flags ?
                           {8'h00, flags_q} : 16'h0000;
    wire [31:0] out_word = {result_q, tail};

    always_comb
    begin
        frame_d = frame_q;
        unique case (frame_q)
            FRAME_IDLE:
                if (cs_fall)
                    frame_d = FRAME_XFER;
            FRAME_XFER:
                if (cs_rise)
                    frame_d = FRAME_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_q     <= FRAME_IDLE;
            cs_prev_q   <= 1'b1;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            frame_q     <= frame_d;
            cs_prev_q   <= cs_s;
            sclk_prev_q <= sclk_s;
        end
    end

    // Single register serves both directions, so chained words pass on
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sr_q    <= 32'h0000_0000;
            count_q <= 6'h00;
        end
        else if (cs_fall)
        begin
            sr_q    <= out_word;
            count_q <= 6'h00;
        end
        else if (capture)
        begin
            sr_q    <= {sr_q[30:0], sdi_s};
            count_q <= full_cnt ? count_q : count_q + 6'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
        end
        else if (cs_fall)
        begin
            sdo_q    <= out_word[31];
            sdo_oe_q <= 1'b1;
        end
        else if (cs_rise)
        begin
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
        end
        else if (launch)
            sdo_q <= sr_q[31];
    end

    // ------------------------------------------------------------
    // Command hand-off and conversion start
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_q        <= `CMD_NOP;
            cmd_valid_q  <= 1'b0;
            conv_start_q <= 1'b0;
        end
        else
        begin
            cmd_valid_q  <= in_frame & cs_rise;
            conv_start_q <= in_frame & cs_rise;
            if (cs_fall)
                cmd_q <= `CMD_NOP;
            else if (in_frame && cs_rise)
                cmd_q <= full_cnt ? sr_q : `CMD_NOP;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata                     = prdata_q;
    assign pready                     = pready_q;
    assign pslverr                    = pslverr_q;
    assign conv_start                 = conv_start_q;
    assign primary_serial_output      = sdo_q;
    assign primary_serial_output_oe   = sdo_oe_q;
    assign multifunction_alarm_pin    = alarm_q;
    assign multifunction_alarm_pin_oe = alarm_oe_q;
    assign command_word               = cmd_q;
    assign command_valid              = cmd_valid_q;

endmodule // adc_alarm_and_chain_port

// File: tb/adc_alarm_and_chain_port_assertions.sv
/* Port checker for the alarm and chain port, bound to its top module.
   Assumes one ref_clk domain and asynchronous active-low rst_b. */
`timescale 1ns/10ps
`include "adc_alarm_cfg.svh"

module adc_alarm_and_chain_port_assertions (
    // Clock and reset
    input wire logic                      ref_clk,
    input wire logic                      rst_b,
    // Register bus
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // Link and pins
    input wire adc_alarm_pkg::serial_in_s link_in,
    input wire logic                      primary_serial_output_oe,
    input wire logic                      multifunction_alarm_pin,
    input wire logic                      multifunction_alarm_pin_oe,
    input wire logic                      conv_start,
    input wire logic [`SHIFT_W-1:0]       command_word,
    input wire logic                      command_valid
);
    import adc_alarm_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ----
    // Capture edges per frame on the raw pins
    // ----
    logic       sel_q, sclk_q;
    logic [5:0] edges_q, edges_d;
    wire        sel = link_in.conversion_start_select;
    wire        rise = link_in.sclk & ~sclk_q & ~sel & (edges_q != 6'h3f);

    assign edges_d = (sel_q & ~sel) ? 6'h00 : edges_q + {5'h00, rise};

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_q   <= 1'b1;
            sclk_q  <= 1'b0;
            edges_q <= 6'h00;
        end
        else
        begin
            sel_q   <= sel;
            sclk_q  <= link_in.sclk;
            edges_q <= edges_d;
        end
    end

    // ----
    // Properties
    // ----
    sequence s_frame_open;
        primary_serial_output_oe && command_word == '0;
    endsequence
    sequence s_frame_close;
        command_valid && conv_start && !primary_serial_output_oe;
    endsequence

    property p_frame_open;
        $fell(sel) |-> ##[2:6] s_frame_open;
    endproperty
    a_frame_open: assert property (p_frame_open)
        else $error("frame did not open");
    property p_frame_close;
        $rose(sel) && primary_serial_output_oe |-> ##[2:6] s_frame_close;
    endproperty
    a_frame_close: assert property (p_frame_close)
        else $error("frame close not decoded");
    property p_frame_hold;
        primary_serial_output_oe && !sel |=> primary_serial_output_oe;
    endproperty
    a_frame_hold: assert property (p_frame_hold)
        else $error("output released in frame");
    property p_short_nop;
        command_valid && edges_d < 6'd32 |-> command_word == '0;
    endproperty
    a_short_nop: assert property (p_short_nop)
        else $error("short frame not a no-op");
    property p_valid_pulse;
        command_valid |=> !command_valid && !conv_start;
    endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("strobe too long");
    property p_pin_func;
        multifunction_alarm_pin |-> multifunction_alarm_pin_oe;
    endproperty
    a_pin_func: assert property (p_pin_func)
        else $error("alarm pin not enabled");
    property p_one_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("no answer after one wait");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
endmodule // adc_alarm_and_chain_port_assertions

bind adc_alarm_and_chain_port adc_alarm_and_chain_port_assertions u_assert (
    .ref_clk, .rst_b, .psel, .penable, .pready, .pslverr, .link_in,
    .primary_serial_output_oe, .multifunction_alarm_pin,
    .multifunction_alarm_pin_oe, .conv_start, .command_word, .command_valid
);

// File: tb/adc_host_model.sv
/* Host controller on the serial link: mode 0 frames, 160 ns sclk.
   Assumes frame() is called just after a ref_clk rising edge. */
`timescale 1ns/10ps

module adc_host_model (
    // Clock
    input wire logic                  ref_clk,
    // Link
    output adc_alarm_pkg::serial_in_s link_in,
    input wire logic                  primary_serial_output,
    input wire logic                  primary_serial_output_oe
);
    import adc_alarm_pkg::*;
    logic sel_q  = 1'b1;
    logic sclk_q = 1'b0;
    logic bit_q  = 1'b0;
    logic idle_q = 1'b0;

    // Released data line toggles so a stale bit never looks valid
    always @(posedge ref_clk)
        idle_q <= ~idle_q;
    assign link_in = {sel_q ? idle_q : bit_q, sclk_q, sel_q};

    task automatic frame(int n, logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        sel_q <= 1'b0;
        repeat (8) @(posedge ref_clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            bit_q <= tx[i];
            repeat (4) @(posedge ref_clk);
            sclk_q <= 1'b1;
            repeat (3) @(posedge ref_clk);
            rx = {rx[62:0], primary_serial_output_oe ? primary_serial_output : 1'bx};
            @(posedge ref_clk);
            sclk_q <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        sel_q <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule // adc_host_model

// File: tb/adc_alarm_and_chain_port_tb.sv
/* Self-checking bench: APB master, converter stub and host link model.
   Assumes a 50 MHz ref_clk and the block's own register map. */
`timescale 1ns/10ps
`include "adc_alarm_cfg.svh"
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module adc_alarm_and_chain_port_tb;
    import adc_alarm_pkg::*;
    logic               ref_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic               conv_done, conv_start, sup_lo, sup_hi, sdo, sdo_oe;
    logic               pin, pin_oe, cmd_valid, e;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0]        pwdata, prdata, cmd, q;
    logic [15:0]        conv_result;
    serial_in_s         link_in;
    logic [63:0]        rx;
    int                 err_count = 0;
    int                 samples_checked = 0;
    // Result in 19:4, expected active flags in 3:0
    logic [19:0]        rows [10] = '{20'h80000, 20'h80011, 20'h7ffc1, 20'h7ffb0,
        20'h10000, 20'h0fff2, 20'h10042, 20'h10050, 20'h00002, 20'hffff1};

    adc_alarm_and_chain_port dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .conv_done, .conv_result, .conv_start,
        .supply_low_cmp(sup_lo), .supply_high_cmp(sup_hi), .link_in,
        .primary_serial_output(sdo), .primary_serial_output_oe(sdo_oe),
        .multifunction_alarm_pin(pin), .multifunction_alarm_pin_oe(pin_oe),
        .command_word(cmd), .command_valid(cmd_valid));
    adc_host_model host (.ref_clk, .link_in, .primary_serial_output(sdo),
        .primary_serial_output_oe(sdo_oe));

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ----
    // Tasks
    // ----
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge ref_clk);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic conv(logic [15:0] r);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic supply(logic lo, logic hi);
        sup_lo <= lo;
        sup_hi <= hi;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic tend(string s);
        $display("[DONE] %s", s);
    endtask
    task automatic summarize();
        $display("[COUNT] checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        summarize();
    end

    // ----
    // Sequence
    // ----
    initial
    begin
        rst_b = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, conv_done, conv_result, sup_lo, sup_hi} = '0;
        repeat (8) @(posedge ref_clk);
        `CHK("reset outs", 5'h00, {pready, sdo_oe, pin, pin_oe, cmd_valid})
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK("release outs", 2'b00, {sdo_oe, cmd_valid})
        rd(`OFS_HIGH_TH);
        `CHK("high th", 32'h0000ffff, q)
        rd(`OFS_LOW_TH);
        `CHK("low th", 32'h0, q)
        rd(`OFS_CTRL);
        `CHK("ctrl", 32'h0, q)
        tend("reset");
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_HIGH_TH, 32'h8000);
        wr(`OFS_LOW_TH, 32'h1000);
        wr(`OFS_HYST, 32'h4);
        foreach (rows[i])
        begin
            conv(rows[i][19:4]);
            `CHK("alarm pin", |rows[i][3:0], pin)
            rd(`OFS_FLAGS);
            `CHK("flags", {24'h0, rows[i][3:0], rows[i][3:0]}, q)
        end
        tend("threshold table");
        conv(16'hffff);
        conv(16'h5000);
        rd(`OFS_FLAGS);
        `CHK("tripped held", 32'h10, q)
        rd(`OFS_FLAGS);
        `CHK("tripped cleared", 32'h0, q)
        rd(`OFS_RESULT);
        `CHK("result", 32'h5000, q)
        tend("tripped");
        supply(1'b1, 1'b0);
        conv(16'h5000);
        `CHK("supply pin", 1'b1, pin)
        rd(`OFS_FLAGS);
        `CHK("supply low", 32'h44, q)
        supply(1'b0, 1'b1);
        conv(16'h5000);
        rd(`OFS_FLAGS);
        `CHK("supply high", 32'h88, q)
        wr(`OFS_CTRL, 32'hd);
        conv(16'hffff);
        `CHK("disabled pin", 2'b10, {pin_oe, pin})
        rd(`OFS_FLAGS);
        `CHK("disabled flags", 32'h0, q)
        wr(`OFS_CTRL, 32'h2);
        @(posedge ref_clk);
        `CHK("pin function", 1'b0, pin_oe)
        tend("supply and disable");
        rd(12'h100);
        `CHK("unmapped", 33'h100000000, {e, q})
        wr(`OFS_RESULT, 32'h1234);
        rd(`OFS_RESULT);
        `CHK("read only", 32'hffff, q)
        tend("bus errors");
        supply(1'b0, 1'b0);
        wr(`OFS_CTRL, 32'h11);
        conv(16'hffff);
        host.frame(32, 64'h12345678, rx);
        `CHK("frame out", 32'hffff0011, rx[31:0])
        `CHK("command", 32'h12345678, cmd)
        host.frame(16, 64'hbeef, rx);
        `CHK("short out", 16'hffff, rx[15:0])
        `CHK("short command", 32'h0, cmd)
        wr(`OFS_CTRL, 32'h0);
        host.frame(40, 64'ha5cafe0123, rx);
        `CHK("long command", 32'hcafe0123, cmd)
        `CHK("chain out", 40'hffff0000a5, rx[39:0])
        tend("serial");
        summarize();
    end
endmodule // adc_alarm_and_chain_port_tb
